/* rtl/usart_status_params.svh */
`ifndef USART_STATUS_PARAMS_SVH
`define USART_STATUS_PARAMS_SVH
// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define STAT_TX_BUF_FREE  0
`define STAT_RX_AVAIL     1
`define STAT_TX_ALL_SENT  2
`define STAT_PARITY_FAULT 3
`define STAT_OVERRUN      4
`define STAT_FRAME_FAULT  5
`define STAT_SYNC_FOUND   6
`define STAT_MODEM_READY  7
// ----------------------------------------
// command byte bit positions
// ----------------------------------------
`define CMD_TX_ENABLE     0
`define CMD_TERM_READY    1
`define CMD_RX_ENABLE     2
`define CMD_SEND_BREAK    3
`define CMD_ERROR_CLEAR   4
`define CMD_REQ_SEND      5
`define CMD_INT_RESET     6
`define CMD_ENTER_HUNT    7
// ----------------------------------------
// mode byte fields and reset values
// ----------------------------------------
`define MODE_BAUD_LSB     0
`define MODE_LEN_LSB      2
`define MODE_PAR_EN       4
`define MODE_PAR_EVEN     5
`define MODE_STOP_LSB     6
`define MODE_RESET        8'h00
`define CMD_RESET         8'h00
`endif

/* rtl/usart_status_pkg.sv */
`default_nettype none
package usart_status_pkg;
	// host access phase: mode byte first, then commands
	typedef enum logic [0:0] {
		PH_MODE,
		PH_CMD
	} setup_phase_t;
	// character length codes
	typedef enum logic [1:0] {
		LEN5 = 2'h0,
		LEN6 = 2'h1,
		LEN7 = 2'h2,
		LEN8 = 2'h3
	} char_len_t;
endpackage
`default_nettype wire

/* rtl/sticky_flag.sv */
`default_nettype none
// one sticky error bit: set wins over clear
module sticky_flag (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic setEvent,
	input  wire logic clearCmd,
	output var  logic flag
);
	// ----------------------------------------
	// flag storage
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flag <= 1'b0;
		end else if (setEvent) begin
			// a fault in the clear cycle must not vanish
			flag <= 1'b1;
		end else if (clearCmd) begin
			flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* rtl/usart_status_access.sv */
// What this block does
// - Status read with select high, anytime
// - Rx-ready, tx-sent, sync bits mirror pins
// - Modem-ready bit is inverted low pin
// - Framing fault sets frame fault flag
// - Overrun sets overrun flag
// - Parity mismatch sets parity fault flag
// - Buffer-free bit tracks empty transmit buffer
// - Tx-ready pin needs empty, clear-to-send, enable
// - Mode 0xB6: async, 6 bits, even, 16x
// - Command 0x27 sets send, rx, terminal, tx
// - Request and terminal pins driven low
// - Unused upper receive bits read zero
// - Ready pins usable as interrupt lines
// - Error flags held until error-clear command
// - Status read clears sync flag only
`include "usart_status_params.svh"
`default_nettype none
module usart_status_access (
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	input  wire logic                   chipSelN,
	input  wire logic                   ctrlSel,
	input  wire logic                   readN,
	input  wire logic                   writeN,
	input  wire logic [7:0]             dataIn,
	output logic      [7:0]             dataOut,
	output logic                        dataOutEnN,
	input  wire logic                   modemReadyN,
	input  wire logic                   clearToSendN,
	input  wire logic                   txBufEmpty,
	input  wire logic                   txAllSentIn,
	input  wire logic                   rxCharStrobe,
	input  wire logic [7:0]             rxCharData,
	input  wire logic                   frameFaultEvt,
	input  wire logic                   parityFaultEvt,
	input  wire logic                   syncFoundEvt,
	output logic                        txLoadStrobe,
	output logic      [7:0]             txLoadData,
	output logic      [7:0]             modeByte,
	output logic      [7:0]             cmdByte,
	output logic                        tx_buffer_free,
	output logic                        rx_char_available,
	output logic                        tx_all_sent,
	output logic                        sync_found,
	output logic                        reqSendN,
	output logic                        termReadyN
);
	import usart_status_pkg::*;

	// ----------------------------------------
	// host strobes, taken on the active level's first cycle
	// ----------------------------------------
	logic                readDly_reg;   // read seen last cycle
	logic                writeDly_reg;  // write seen last cycle
	logic                rdAct;
	logic                wrAct;
	logic                rdStart;
	logic                wrStart;
	logic                statusRead;
	logic                dataRead;
	logic                cmdWrite;
	logic                dataWrite;
	setup_phase_t        phase_reg;     // expecting mode or command
	logic [7:0]          rxHold_reg;    // received character buffer
	logic                rxFull_reg;    // buffer holds unread char
	logic                overrunEvt;
	logic                errClear;
	logic                frameFlag;
	logic                overrunFlag;
	logic                parityFlag;
	logic                syncFlag_reg;  // internal sync flip-flop
	logic [7:0]          statusWord;
	logic [7:0]          rxMasked;
	logic [7:0]          dataOut_next;

	assign rdAct      = !chipSelN && !readN;
	assign wrAct      = !chipSelN && !writeN;
	assign rdStart    = rdAct && !readDly_reg;
	assign wrStart    = wrAct && !writeDly_reg;
	assign statusRead = rdStart && ctrlSel;
	assign dataRead   = rdStart && !ctrlSel;
	assign cmdWrite   = wrStart && ctrlSel && (phase_reg == PH_CMD);
	assign dataWrite  = wrStart && !ctrlSel;
	// error-clear only on a command write
	assign errClear   = cmdWrite && dataIn[`CMD_ERROR_CLEAR];
	assign overrunEvt = rxCharStrobe && rxFull_reg && !(dataRead);

	// ----------------------------------------
	// strobe edge history
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			readDly_reg  <= 1'b0;
			writeDly_reg <= 1'b0;
		end else begin
			readDly_reg  <= rdAct;
			writeDly_reg <= wrAct;
		end
	end

	// ----------------------------------------
	// mode and command registers
	// ----------------------------------------
	// first control write is the mode byte; internal reset returns to it
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase_reg <= PH_MODE;
			modeByte  <= `MODE_RESET;
			cmdByte   <= `CMD_RESET;
		end else if (wrStart && ctrlSel) begin
			if (phase_reg == PH_MODE) begin
				// mode byte stored for framing engines
				modeByte  <= dataIn;
				phase_reg <= PH_CMD;
			end else if (dataIn[`CMD_INT_RESET]) begin
				// internal reset: back to mode phase
				phase_reg <= PH_MODE;
				cmdByte   <= `CMD_RESET;
			end else begin
				cmdByte <= dataIn;
			end
		end
	end

	// ----------------------------------------
	// modem control pins
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reqSendN   <= 1'b1;
			termReadyN <= 1'b1;
		end else begin
			reqSendN   <= !cmdByte[`CMD_REQ_SEND];
			termReadyN <= !cmdByte[`CMD_TERM_READY];
		end
	end

	// ----------------------------------------
	// transmit load path
	// ----------------------------------------
	// no overwrite guard: host is trusted to poll buffer-free
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			txLoadStrobe <= 1'b0;
			txLoadData   <= 8'h00;
		end else begin
			txLoadStrobe <= dataWrite;
			if (dataWrite) begin
				txLoadData <= dataIn;
			end
		end
	end

	// ----------------------------------------
	// receive buffer
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rxFull_reg <= 1'b0;
			rxHold_reg <= 8'h00;
		end else if (rxCharStrobe) begin
			// newest char wins, older one destroyed
			rxFull_reg <= 1'b1;
			rxHold_reg <= rxCharData;
		end else if (dataRead) begin
			rxFull_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// sticky error flags
	// ----------------------------------------
	// frame fault flag
	sticky_flag u_frame (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.setEvent (frameFaultEvt && cmdByte[`CMD_RX_ENABLE]),
		.clearCmd (errClear),
		.flag     (frameFlag)
	);
	sticky_flag u_overrun (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.setEvent (overrunEvt && cmdByte[`CMD_RX_ENABLE]),
		.clearCmd (errClear),
		.flag     (overrunFlag)
	);
	sticky_flag u_parity (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.setEvent (parityFaultEvt && cmdByte[`CMD_RX_ENABLE]),
		.clearCmd (errClear),
		.flag     (parityFlag)
	);

	// ----------------------------------------
	// sync detect flip-flop
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			syncFlag_reg <= 1'b0;
		end else if (syncFoundEvt) begin
			// detection beats a simultaneous status read
			syncFlag_reg <= 1'b1;
		end else if (statusRead) begin
			syncFlag_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// status pins
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_buffer_free    <= 1'b0;
			rx_char_available <= 1'b0;
			tx_all_sent       <= 1'b0;
			sync_found        <= 1'b0;
		end else begin
			tx_buffer_free    <= txBufEmpty && !clearToSendN && cmdByte[`CMD_TX_ENABLE];
			rx_char_available <= rxFull_reg && cmdByte[`CMD_RX_ENABLE];
			tx_all_sent       <= txAllSentIn;
			sync_found        <= syncFlag_reg;
		end
	end

	// ----------------------------------------
	// status word and read data
	// ----------------------------------------
	always_comb begin
		statusWord = 8'h00;
		// buffer-free bit ignores cts and enable
		statusWord[`STAT_TX_BUF_FREE]  = txBufEmpty;
		statusWord[`STAT_RX_AVAIL]     = rx_char_available;
		statusWord[`STAT_TX_ALL_SENT]  = tx_all_sent;
		statusWord[`STAT_SYNC_FOUND]   = sync_found;
		statusWord[`STAT_PARITY_FAULT] = parityFlag;
		statusWord[`STAT_OVERRUN]      = overrunFlag;
		statusWord[`STAT_FRAME_FAULT]  = frameFlag;
		statusWord[`STAT_MODEM_READY]  = !modemReadyN;
	end

	// mask bits above the character length
	always_comb begin
		unique case (char_len_t'(modeByte[`MODE_LEN_LSB +: 2]))
			LEN5: rxMasked = rxHold_reg & 8'h1F;
			LEN6: rxMasked = rxHold_reg & 8'h3F;
			LEN7: rxMasked = rxHold_reg & 8'h7F;
			LEN8: rxMasked = rxHold_reg;
		endcase
	end

	always_comb begin
		dataOut_next = dataOut;
		if (rdStart) begin
			dataOut_next = ctrlSel ? statusWord : rxMasked;
		end
	end

	// read samples here; status read clears sync, data read empties rx buffer
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dataOut    <= 8'h00;
			dataOutEnN <= 1'b1;
		end else begin
			dataOut    <= dataOut_next;
			dataOutEnN <= !rdAct;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_txpin;
		@(posedge clk_sys) disable iff (reset)
		tx_buffer_free |-> $past(txBufEmpty && !clearToSendN && cmdByte[`CMD_TX_ENABLE]);
	endproperty
	a_txpin: assert property (p_txpin) else $error("tx ready pin without all conditions");

	property p_modem;
		@(posedge clk_sys) disable iff (reset)
		statusRead |=> dataOut[`STAT_MODEM_READY] == !$past(modemReadyN);
	endproperty
	a_modem: assert property (p_modem) else $error("modem bit not inverted pin");

	property p_bufree;
		@(posedge clk_sys) disable iff (reset)
		statusRead |=> dataOut[`STAT_TX_BUF_FREE] == $past(txBufEmpty);
	endproperty
	a_bufree: assert property (p_bufree) else $error("buffer-free bit wrong");

	property p_errhold;
		@(posedge clk_sys) disable iff (reset)
		frameFlag && !errClear |=> frameFlag;
	endproperty
	a_errhold: assert property (p_errhold) else $error("frame flag lost without clear");

	property p_frameset;
		@(posedge clk_sys) disable iff (reset)
		frameFaultEvt && cmdByte[`CMD_RX_ENABLE] |=> frameFlag;
	endproperty
	a_frameset: assert property (p_frameset) else $error("frame fault not flagged");

	property p_parset;
		@(posedge clk_sys) disable iff (reset)
		parityFaultEvt && cmdByte[`CMD_RX_ENABLE] |=> parityFlag;
	endproperty
	a_parset: assert property (p_parset) else $error("parity fault not flagged");

	property p_ovset;
		@(posedge clk_sys) disable iff (reset)
		rxCharStrobe && rxFull_reg && !dataRead && cmdByte[`CMD_RX_ENABLE] |=> overrunFlag;
	endproperty
	a_ovset: assert property (p_ovset) else $error("overrun not flagged");

	property p_syncclr;
		@(posedge clk_sys) disable iff (reset)
		statusRead && !syncFoundEvt |=> !syncFlag_reg ##1 !sync_found;
	endproperty
	a_syncclr: assert property (p_syncclr) else $error("sync flag survived status read");

	property p_rtspin;
		@(posedge clk_sys) disable iff (reset)
		cmdWrite && !dataIn[`CMD_INT_RESET] |=> ##1 reqSendN == !$past(dataIn[`CMD_REQ_SEND], 2);
	endproperty
	a_rtspin: assert property (p_rtspin) else $error("request pin not following command");

	property p_upper;
		@(posedge clk_sys) disable iff (reset)
		dataRead && modeByte[`MODE_LEN_LSB +: 2] == 2'h1 |=> dataOut[7:6] == 2'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper receive bits not zero");
endmodule
`default_nettype wire

/* bench/host_cpu_model.sv */
`default_nettype none
// host processor on the byte-wide parallel bus
module host_cpu_model (
	input  wire logic       clk_sys,
	output logic            chipSelN,
	output logic            ctrlSel,
	output logic            readN,
	output logic            writeN,
	output logic      [7:0] dataIn,
	input  wire logic [7:0] dataOut,
	input  wire logic       dataOutEnN
);
	timeunit 1ns;
	timeprecision 100ps;
	// bus idle: nothing selected, no strobe
	initial begin
		chipSelN = 1'b1;
		ctrlSel  = 1'b0;
		readN    = 1'b1;
		writeN   = 1'b1;
		dataIn   = 8'h00;
	end
	// read cycle
	// strobe held until the enable is seen low, bounded wait
	task automatic rd(input logic sel, output logic [7:0] val, output bit ok);
		int n;
		ok = 1'b0;
		chipSelN <= 1'b0;
		ctrlSel <= sel;
		readN <= 1'b0;
		for (n = 0; n < 8 && !ok; n++) begin
			@(posedge clk_sys);
			ok = (dataOutEnN === 1'b0);
		end
		val = dataOut;
		chipSelN <= 1'b1;
		readN <= 1'b1;
		// idle cycle so the next strobe is seen as new
		@(posedge clk_sys);
	endtask
	// write cycle
	// released data lines show the inverse, not a stale copy
	task automatic wr(input logic sel, input logic [7:0] val);
		chipSelN <= 1'b0;
		ctrlSel <= sel;
		writeN <= 1'b0;
		dataIn <= val;
		@(posedge clk_sys);
		chipSelN <= 1'b1;
		writeN <= 1'b1;
		dataIn <= ~val;
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

/* bench/usart_status_access_bench.sv */
`default_nettype none
`include "usart_status_params.svh"
`define CHK(what, exp, got) begin \
	testsRun++; \
	if ((got) !== (exp)) begin \
		nFail++; \
		$display("[ERR] %s expected %h seen %h", what, exp, got); \
	end \
end
module usart_status_access_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import usart_status_pkg::*;
	// ------
	// stimulus and observed nets
	// ------
	logic       clk_sys      = 1'b0;
	logic       reset        = 1'b1;
	logic       modemReadyN  = 1'b1;
	logic       clearToSendN = 1'b1;
	logic       txBufEmpty   = 1'b0;
	logic       txAllSentIn  = 1'b0;
	logic [3:0] evts         = 4'h0; // sync, parity, frame, rx strobe
	logic [7:0] rxData       = 8'h00;
	wire        chipSelN, ctrlSel, readN, writeN, dataOutEnN, txLoadStrobe;
	wire  [7:0] dataIn, dataOut, txLoadData, modeByte, cmdByte;
	wire        tx_buffer_free, rx_char_available, tx_all_sent, sync_found;
	wire        reqSendN, termReadyN;
	int         nFail        = 0;
	int         testsRun     = 0;
	int         cycles       = 0;
	int         nLoads       = 0; // cycles with the load strobe high
	logic [7:0] lastLoad     = 8'h00;
	// 4 ns clock
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	usart_status_access dut (
		.clk_sys(clk_sys), .reset(reset), .chipSelN(chipSelN), .ctrlSel(ctrlSel),
		.readN(readN), .writeN(writeN), .dataIn(dataIn), .dataOut(dataOut),
		.dataOutEnN(dataOutEnN), .modemReadyN(modemReadyN),
		.clearToSendN(clearToSendN), .txBufEmpty(txBufEmpty),
		.txAllSentIn(txAllSentIn), .rxCharStrobe(evts[0]), .rxCharData(rxData),
		.frameFaultEvt(evts[1]), .parityFaultEvt(evts[2]), .syncFoundEvt(evts[3]),
		.txLoadStrobe(txLoadStrobe), .txLoadData(txLoadData), .modeByte(modeByte),
		.cmdByte(cmdByte), .tx_buffer_free(tx_buffer_free),
		.rx_char_available(rx_char_available), .tx_all_sent(tx_all_sent),
		.sync_found(sync_found), .reqSendN(reqSendN), .termReadyN(termReadyN)
	);
	host_cpu_model host (
		.clk_sys(clk_sys), .chipSelN(chipSelN), .ctrlSel(ctrlSel), .readN(readN),
		.writeN(writeN), .dataIn(dataIn), .dataOut(dataOut), .dataOutEnN(dataOutEnN)
	);
	// ------
	// helpers
	// ------
	task automatic finishTest;
		$display("checks %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// load strobe watch and hang guard; the run needs well under 1000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (txLoadStrobe === 1'b1) begin
			nLoads++;
			lastLoad = txLoadData;
		end
		if (cycles == 3000) begin
			nFail++;
			finishTest();
		end
	end
	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one-cycle event pulse from the framing side, then let the pins settle
	task automatic pulse(input logic [3:0] m, input logic [7:0] ch);
		evts <= m;
		rxData <= ch;
		@(posedge clk_sys);
		evts <= 4'h0;
		rxData <= ~ch;
		waitc(3);
	endtask
	task automatic chkRd(input logic sel, input logic [7:0] exp, input string what);
		logic [7:0] v;
		bit         ok;
		host.rd(sel, v, ok);
		`CHK({what, " enable"}, 1'b1, ok)
		`CHK(what, exp, v)
	endtask
	// internal reset, a new mode, receiver on, then one character read back
	task automatic reinit(input logic [7:0] mode, input logic [7:0] exp, input string what);
		host.wr(1'b1, 8'h40);
		waitc(1);
		`CHK("internal reset", 8'h00, cmdByte)
		`CHK("pins released", 2'h3, {reqSendN, termReadyN})
		host.wr(1'b1, mode);
		host.wr(1'b1, 8'h04);
		pulse(4'h1, 8'hED);
		chkRd(1'b0, exp, what);
	endtask
	// ------
	// main sequence
	// ------
	initial begin
		waitc(10);
		reset <= 1'b0;
		waitc(2);
		`CHK("reset pins", 3'h7, {dataOutEnN, reqSendN, termReadyN})
		`CHK("reset config", 16'h0000, {modeByte, cmdByte})
		chkRd(1'b1, 8'h00, "reset status");
		$display("test reset done");
		host.wr(1'b1, 8'hB6);
		host.wr(1'b1, 8'h27);
		waitc(2);
		`CHK("mode", 8'hB6, modeByte)
		`CHK("length", LEN6, modeByte[`MODE_LEN_LSB +: 2])
		`CHK("command", 8'h27, cmdByte)
		`CHK("modem pins", 2'h0, {reqSendN, termReadyN})
		$display("test setup done");
		txBufEmpty <= 1'b1;
		clearToSendN <= 1'b0;
		modemReadyN <= 1'b0;
		txAllSentIn <= 1'b1;
		waitc(3);
		`CHK("tx ready pin", 1'b1, tx_buffer_free)
		`CHK("all sent pin", 1'b1, tx_all_sent)
		chkRd(1'b1, 8'h85, "status");
		// data written only after buffer-free was seen in status
		host.wr(1'b0, 8'h2D);
		waitc(1);
		`CHK("load count", 1, nLoads)
		`CHK("load data", 8'h2D, lastLoad)
		clearToSendN <= 1'b1;
		waitc(3);
		`CHK("tx ready pin", 1'b0, tx_buffer_free)
		chkRd(1'b1, 8'h85, "status no cts");
		modemReadyN <= 1'b1;
		clearToSendN <= 1'b0;
		waitc(3);
		chkRd(1'b1, 8'h05, "status modem off");
		$display("test pins done");
		pulse(4'h1, 8'hED);
		`CHK("rx ready pin", 1'b1, rx_char_available)
		chkRd(1'b1, 8'h07, "status rx");
		chkRd(1'b0, 8'h2D, "rx data");
		waitc(2);
		`CHK("rx ready pin", 1'b0, rx_char_available)
		$display("test receive done");
		pulse(4'h7, 8'h11);
		pulse(4'h1, 8'h12);
		chkRd(1'b1, 8'h3F, "errors");
		chkRd(1'b1, 8'h3F, "errors reread");
		host.wr(1'b1, 8'h27);
		chkRd(1'b1, 8'h3F, "errors kept");
		chkRd(1'b0, 8'h12, "overrun data");
		host.wr(1'b1, 8'h37);
		waitc(2);
		chkRd(1'b1, 8'h05, "errors cleared");
		$display("test errors done");
		pulse(4'h8, 8'h00);
		`CHK("sync pin", 1'b1, sync_found)
		chkRd(1'b1, 8'h45, "sync status");
		waitc(1);
		`CHK("sync pin", 1'b0, sync_found)
		chkRd(1'b1, 8'h05, "sync cleared");
		$display("test sync done");
		host.wr(1'b1, 8'h26);
		waitc(2);
		`CHK("tx ready off", 1'b0, tx_buffer_free)
		chkRd(1'b1, 8'h05, "status tx off");
		txBufEmpty <= 1'b0;
		waitc(3);
		chkRd(1'b1, 8'h04, "buffer full");
		$display("test enable done");
		// eight, seven and five bit length codes, each after an internal reset
		reinit(8'h0C, 8'hED, "rx eight bit");
		reinit(8'h08, 8'h6D, "rx seven bit");
		reinit(8'h00, 8'h0D, "rx five bit");
		$display("test reinit done");
		finishTest();
	end
endmodule
`default_nettype wire
